// ---- rtl/pfi_out_div.sv ----
`default_nettype none
module pfi_out_div
    import pfi_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control.
    input  wire logic       run_i,
    input  wire logic       en_i,
    input  wire logic [2:0] div_sel_i,
    input  wire logic       align_i,
    input  wire logic       tick_i,
    // Synthesized clock.
    output logic            clk_o
);
    logic [7:0] cnt_ff;
    logic [7:0] half;

    // Half period in post-divider ticks; the output toggles once per half period.
    assign half = 8'(8'h01 << div_sel_i);

    // An aligning pulse restarts the divider so the output edge follows the reference.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i || !en_i || align_i)
        begin
            cnt_ff <= 8'h00;
            clk_o  <= 1'b0;
        end
        else if (tick_i)
        begin
            if (cnt_ff == half - 8'h01)
            begin
                cnt_ff <= 8'h00;
                clk_o  <= ~clk_o;
            end
            else
            begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // A disabled output sits low.
    property p_off_low;
        @(posedge clk_i) disable iff (rst_i) !en_i |=> !clk_o;
    endproperty
    a_off_low: assert property (p_off_low) else $error("disabled output not low");

    // A free-running output toggles only on a tick at the end of a half period.
    // A forced restart in the cycle before may also drop it, so that case is excluded.
    property p_toggle_cause;
        @(posedge clk_i) disable iff (rst_i)
        ($past(!rst_i && en_i && run_i && !align_i) && $changed(clk_o))
            |-> $past(tick_i) && $past(cnt_ff) == $past(half) - 8'h01;
    endproperty
    a_toggle_cause: assert property (p_toggle_cause) else $error("output toggled early");
endmodule
`default_nettype wire

// ---- rtl/pfi_pkg.sv ----
`default_nettype none
package pfi_pkg;
    // Bus geometry.
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    // Register byte offsets.
    localparam logic [AW-1:0] ADR_CTRL = 8'h00;
    localparam logic [AW-1:0] ADR_DIV  = 8'h04;
    localparam logic [AW-1:0] ADR_OUT  = 8'h08;
    localparam logic [AW-1:0] ADR_STAT = 8'h0c;
    // Control fields: feedback mode and output enables.
    localparam int unsigned CTRL_FB_LSB = 0;
    localparam int unsigned CTRL_EN_LSB = 4;
    localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
    // Divider fields: N, M and log2 of O.
    localparam int unsigned DIV_N_LSB = 0;
    localparam int unsigned DIV_M_LSB = 8;
    localparam int unsigned DIV_O_LSB = 16;
    localparam logic [DW-1:0] DIV_RST = 32'h0000_0101;
    // Output divider selects, one 3-bit field every 4 bits; k means divide by 2^(k+1).
    localparam int unsigned OUT_FLD_STEP = 4;
    localparam logic [DW-1:0] OUT_RST = 32'h0000_0000;
    // Status fields.
    localparam int unsigned STAT_LOCK_BIT = 0;
    localparam int unsigned STAT_REF_LSB  = 4;
    localparam int unsigned STAT_PER_LSB  = 16;
    // Counts.
    localparam int unsigned NUM_OUT  = 3;
    localparam int unsigned NUM_REF  = 4;
    localparam int unsigned PER_W    = 16;
    localparam logic [3:0]  LOCK_CNT = 4'h8;
    // Timing.
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned RST_MIN_NS    = 10;
    localparam int unsigned RST_MIN_CYC   =
        (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Feedback modes.
    typedef enum logic [1:0] {
        PFI_FB_INTERNAL = 2'h0,
        PFI_FB_LOCAL    = 2'h1,
        PFI_FB_CORE     = 2'h2
    } pfi_fb_t;
endpackage
`default_nettype wire

// ---- rtl/pfi_top.sv ----
// Design decisions made here: the Wishbone register port and the register offsets.
`default_nettype none
module pfi_top
    import pfi_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone slave.
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [DW-1:0] wb_dat_i,
    output logic      [DW-1:0] wb_dat_o,
    output logic               wb_ack_o,
    // Fabric-side pins.
    input  wire logic [3:0]    ref_clk_i,
    input  wire logic [1:0]    ref_select_i,
    input  wire logic          pll_reset_n_i,
    input  wire logic          fabric_feedback_clk_i,
    // Synthesized clocks and lock.
    output logic               synth_clk_out_0_o,
    output logic               synth_clk_out_1_o,
    output logic               synth_clk_out_2_o,
    output logic               locked_o
);
    localparam int unsigned NSYNC = 8;

    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, stab_ff;
    logic [DW-1:0]    ctrl_ff, div_ff, out_ff;
    logic [1:0]       sel_ff;
    logic             run_ff;
    logic [3:0]       low_cnt_ff;
    logic             ref_prev_ff, fb_prev_ff, fb_seen_ff;
    logic [3:0]       n_cnt_ff;
    logic [PER_W-1:0] per_cnt_ff, per_last_ff;
    logic [PER_W:0]   acc_ff;
    logic [3:0]       good_cnt_ff;
    logic [7:0]       o_cnt_ff;
    logic             ref_now, ref_rise, fb_rise, pfd_tick, vco_tick, post_tick;
    logic [PER_W:0]   nxt_acc_sum;
    logic [3:0]       n_val;
    logic [7:0]       m_val, o_val;
    logic             align, per_ok, wr_en;
    logic [NUM_OUT-1:0] clk_out;
    pfi_fb_t          fb_mode;

    // Applies Wishbone byte enables to a register word.
    function automatic logic [DW-1:0] wmask(input logic [DW-1:0] old,
                                            input logic [DW-1:0] din,
                                            input logic [3:0] sel);
        logic [DW-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                r[b*8 +: 8] = din[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pins arrive from other clock domains; a change counts once stages two and three agree.
    generate
        for (genvar i = 0; i < NSYNC; i++)
        begin : g_sync
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    s1_ff[i]   <= 1'b0;
                    s2_ff[i]   <= 1'b0;
                    s3_ff[i]   <= 1'b0;
                    stab_ff[i] <= 1'b0;
                end
                else
                begin
                    s1_ff[i] <= (i < 4) ? ref_clk_i[i % 4] :
                                (i < 6) ? ref_select_i[(i - 4) % 2] :
                                (i == 6) ? pll_reset_n_i : fabric_feedback_clk_i;
                    s2_ff[i] <= s1_ff[i];
                    s3_ff[i] <= s2_ff[i];
                    if (s2_ff[i] == s3_ff[i])
                    begin
                        stab_ff[i] <= s3_ff[i];
                    end
                end
            end
        end
    endgenerate

    // Register fields.
    assign fb_mode = pfi_fb_t'(ctrl_ff[CTRL_FB_LSB +: 2]);
    assign n_val   = div_ff[DIV_N_LSB +: 4];
    assign m_val   = div_ff[DIV_M_LSB +: 8];
    assign o_val   = 8'(8'h01 << div_ff[DIV_O_LSB +: 2]);

    // Reset pin filter: a low shorter than the minimum pulse does not stop the synthesizer.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            low_cnt_ff <= 4'h0;
            run_ff     <= 1'b0;
        end
        else if (stab_ff[6])
        begin
            low_cnt_ff <= 4'h0;
            run_ff     <= 1'b1;
        end
        else
        begin
            if (low_cnt_ff != 4'hf)
            begin
                low_cnt_ff <= low_cnt_ff + 4'h1;
            end
            if (low_cnt_ff >= 4'(RST_MIN_CYC - 1))
            begin
                run_ff <= 1'b0;
            end
        end
    end

    // The select is latched only while held in reset, so a glitchy switch cannot reach the loop.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_ff <= 2'h0;
        end
        else if (!run_ff)
        begin
            sel_ff <= stab_ff[5:4];
        end
    end

    // Selected reference and feedback edges.
    assign ref_now  = stab_ff[sel_ff];
    assign ref_rise = ref_now && !ref_prev_ff;
    assign fb_rise  = stab_ff[7] && !fb_prev_ff;
    assign pfd_tick = run_ff && ref_rise && (4'(n_cnt_ff + 4'h1) >= n_val);
    assign align    = pfd_tick && (fb_mode == PFI_FB_LOCAL || fb_mode == PFI_FB_CORE);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_prev_ff <= 1'b0;
            fb_prev_ff  <= 1'b0;
        end
        else
        begin
            ref_prev_ff <= ref_now;
            fb_prev_ff  <= stab_ff[7];
        end
    end

    // Pre-divider N and detector period measurement in system clocks.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_ff)
        begin
            n_cnt_ff    <= 4'h0;
            per_cnt_ff  <= '0;
            per_last_ff <= '0;
        end
        else
        begin
            if (per_cnt_ff != '1)
            begin
                per_cnt_ff <= per_cnt_ff + 1'b1;
            end
            if (pfd_tick)
            begin
                n_cnt_ff    <= 4'h0;
                per_cnt_ff  <= 16'h0001; // Restarting at one stores the whole period.
                per_last_ff <= per_cnt_ff;
            end
            else if (ref_rise)
            begin
                n_cnt_ff <= n_cnt_ff + 4'h1;
            end
        end
    end

    // Multiplier M: M evenly spread ticks per detector period; too coarse for M above it.
    assign nxt_acc_sum = acc_ff + {{(PER_W - 7){1'b0}}, m_val};
    assign vco_tick    = run_ff && per_last_ff != '0 && nxt_acc_sum >= {1'b0, per_last_ff};

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_ff || align)
        begin
            acc_ff <= '0;
        end
        else if (vco_tick)
        begin
            acc_ff <= nxt_acc_sum - {1'b0, per_last_ff};
        end
        else
        begin
            acc_ff <= nxt_acc_sum;
        end
    end

    // Post-divider O.
    assign post_tick = vco_tick && (o_cnt_ff + 8'h01 >= o_val);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_ff || align)
        begin
            o_cnt_ff <= 8'h00;
        end
        else if (post_tick)
        begin
            o_cnt_ff <= 8'h00;
        end
        else if (vco_tick)
        begin
            o_cnt_ff <= o_cnt_ff + 8'h01;
        end
    end

    // Per-output dividers and enables.
    generate
        for (genvar k = 0; k < NUM_OUT; k++)
        begin : g_out
            pfi_out_div u_div (
                .clk_i     (clk_i),
                .rst_i     (rst_i),
                .run_i     (run_ff),
                .en_i      (ctrl_ff[CTRL_EN_LSB + k]),
                .div_sel_i (out_ff[k*OUT_FLD_STEP +: 3]),
                .align_i   (align),
                .tick_i    (post_tick),
                .clk_o     (clk_out[k])
            );
        end
    endgenerate
    assign synth_clk_out_0_o = clk_out[0];
    assign synth_clk_out_1_o = clk_out[1];
    assign synth_clk_out_2_o = clk_out[2];

    // Lock: stable period for LOCK_CNT detector ticks; core mode also needs returned edges.
    assign per_ok = (per_cnt_ff <= per_last_ff + 1'b1) && (per_cnt_ff + 1'b1 >= per_last_ff)
                    && (fb_mode != PFI_FB_CORE || fb_seen_ff || fb_rise);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_ff)
        begin
            good_cnt_ff <= 4'h0;
            locked_o    <= 1'b0;
            fb_seen_ff  <= 1'b0;
        end
        else if (per_cnt_ff == '1)
        begin
            good_cnt_ff <= 4'h0;
            locked_o    <= 1'b0;
        end
        else if (pfd_tick)
        begin
            fb_seen_ff <= 1'b0;
            if (!per_ok || per_last_ff == '0)
            begin
                good_cnt_ff <= 4'h0;
                locked_o    <= 1'b0;
            end
            else if (good_cnt_ff == LOCK_CNT - 4'h1)
            begin
                locked_o <= 1'b1;
            end
            else
            begin
                good_cnt_ff <= good_cnt_ff + 4'h1;
            end
        end
        else if (fb_rise)
        begin
            fb_seen_ff <= 1'b1;
        end
    end

    // Wishbone: one wait state, write lands on the acknowledging edge.
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                ADR_CTRL: wb_dat_o <= ctrl_ff;
                ADR_DIV:  wb_dat_o <= div_ff;
                ADR_OUT:  wb_dat_o <= out_ff;
                ADR_STAT: wb_dat_o <= {per_last_ff, 10'h000, sel_ff, 3'h0, locked_o};
                default:  wb_dat_o <= '0;
            endcase
        end
    end

    // Writable registers; unmapped writes are acknowledged and dropped.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= CTRL_RST;
            div_ff  <= DIV_RST;
            out_ff  <= OUT_RST;
        end
        else if (wr_en)
        begin
            if (wb_adr_i == ADR_CTRL)
            begin
                ctrl_ff <= wmask(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_0073;
            end
            if (wb_adr_i == ADR_DIV)
            begin
                div_ff <= wmask(div_ff, wb_dat_i, wb_sel_i) & 32'h0003_ff0f;
            end
            if (wb_adr_i == ADR_OUT)
            begin
                out_ff <= wmask(out_ff, wb_dat_i, wb_sel_i) & 32'h0000_0777;
            end
        end
    end

    property p_sel_frozen;
        @(posedge clk_i) disable iff (rst_i) run_ff && $past(run_ff) |-> $stable(sel_ff);
    endproperty
    a_sel_frozen: assert property (p_sel_frozen) else $error("select moved while running");

    property p_reset_holds;
        @(posedge clk_i) disable iff (rst_i) !run_ff |=> acc_ff == '0 && o_cnt_ff == 8'h00;
    endproperty
    a_reset_holds: assert property (p_reset_holds) else $error("loop ran in reset");

    property p_lock_cause;
        @(posedge clk_i) disable iff (rst_i)
        $rose(locked_o) |-> $past(pfd_tick) && $past(good_cnt_ff) == LOCK_CNT - 4'h1;
    endproperty
    a_lock_cause: assert property (p_lock_cause) else $error("lock rose without stable run");

    property p_unlock_stop;
        @(posedge clk_i) disable iff (rst_i) run_ff && per_cnt_ff == '1 |=> !locked_o;
    endproperty
    a_unlock_stop: assert property (p_unlock_stop) else $error("lock held without reference");

    property p_post_div;
        @(posedge clk_i) disable iff (rst_i) post_tick |-> vco_tick && o_cnt_ff == o_val - 8'h01;
    endproperty
    a_post_div: assert property (p_post_div) else $error("post divider miscounted");

    property p_pfd_rate;
        @(posedge clk_i) disable iff (rst_i)
        pfd_tick && n_val != 4'h0 |-> ref_rise && n_cnt_ff == n_val - 4'h1;
    endproperty
    a_pfd_rate: assert property (p_pfd_rate) else $error("detector tick not at N");

    property p_align;
        @(posedge clk_i) disable iff (rst_i) align |=> acc_ff == '0 && o_cnt_ff == 8'h00;
    endproperty
    a_align: assert property (p_align) else $error("phase not realigned");

    property p_lock_low_reset;
        @(posedge clk_i) disable iff (rst_i) !run_ff |=> !locked_o ##1 !locked_o [*2];
    endproperty
    a_lock_low_reset: assert property (p_lock_low_reset) else $error("lock high after reset");
endmodule
`default_nettype wire

// ---- verif/pfi_fabric_model.sv ----
`default_nettype none
// Fabric-side partner: reference clocks, reset, select and feedback loop.
module pfi_fabric_model
(
    // System clock and returned output clock.
    input  wire logic       clk_i,
    input  wire logic       clk_out_0_i,
    // Pins towards the synthesizer.
    output logic      [3:0] ref_clk_o,
    output logic      [1:0] ref_select_o,
    output logic            pll_reset_n_o,
    output logic            fabric_feedback_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half periods in ns; reference 2 is slower so the selection shows in the period.
    int half_ns [4] = '{24, 24, 40, 24};

    // Start in reset with reference 0 selected.
    initial
    begin
        ref_clk_o     = 4'h0;
        ref_select_o  = 2'h0;
        pll_reset_n_o = 1'b0;
    end

    // Free-running references, unrelated in phase to the system clock.
    for (genvar k = 0; k < 4; k++)
    begin : g_ref
        always
        begin
            #(half_ns[k]);
            ref_clk_o[k] = ~ref_clk_o[k];
        end
    end

    // The first output clock is always looped back; only core mode uses it.
    assign fabric_feedback_clk_o = clk_out_0_i;

    // Lower reset first, then move the select while held.
    task automatic hold_reset(input logic [1:0] s);
        @(posedge clk_i);
        pll_reset_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        ref_select_o <= s;
    endtask

    // Eight cycles low in all, well above the minimum pulse.
    task automatic release_reset();
        repeat (4) @(posedge clk_i);
        pll_reset_n_o <= 1'b1;
    endtask

    // Deliberately moves the select while running, to see it refused.
    task automatic bad_select(input logic [1:0] s);
        @(posedge clk_i);
        ref_select_o <= s;
    endtask
endmodule
`default_nettype wire

// ---- verif/pfi_top_tb.sv ----
`default_nettype none
module pfi_top_tb
    import pfi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic          cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [AW-1:0] adr = '0;
    logic [3:0]    sel = 4'h0;
    logic [DW-1:0] wdat = '0, rdat, q;
    logic [3:0]    ref_clk;
    logic [1:0]    ref_sel;
    logic          rst_n, fb_clk, c0, c1, c2, locked_o, wb_ack_o;
    int            num_errors = 0;
    int            check_count = 0;
    int            n0, n1, n2;
    wire logic [2:0] outs;
    assign outs = {c2, c1, c0};

    // 200 MHz system clock.
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    pfi_top pfi_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(wb_ack_o), .ref_clk_i(ref_clk), .ref_select_i(ref_sel),
        .pll_reset_n_i(rst_n), .fabric_feedback_clk_i(fb_clk), .synth_clk_out_0_o(c0),
        .synth_clk_out_1_o(c1), .synth_clk_out_2_o(c2), .locked_o(locked_o));

    pfi_fabric_model pfi_fabric_model_i (.clk_i(clk_i), .clk_out_0_i(c0),
        .ref_clk_o(ref_clk), .ref_select_o(ref_sel), .pll_reset_n_o(rst_n),
        .fabric_feedback_clk_o(fb_clk));

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Range compare for measured periods and edge counts; unknown fails.
    task automatic chk_rng(input logic [DW-1:0] got, input int lo, input int hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // One classic cycle; held until ack is sampled, then one idle cycle follows.
    task automatic wb_xfer(input logic w, input logic [AW-1:0] a,
                           input logic [DW-1:0] d, input logic [3:0] s,
                           output logic [DW-1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
            chk(32'h0, 32'h1);
    endtask

    task automatic wb_wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                         input logic [3:0] s = 4'hf);
        logic [DW-1:0] r;
        wb_xfer(1'b1, a, d, s, r);
    endtask

    task automatic wb_rd(input logic [AW-1:0] a, output logic [DW-1:0] r);
        wb_xfer(1'b0, a, '0, 4'hf, r);
    endtask

    // Bounded wait for a lock level, then compare it.
    task automatic wait_lock(input logic e, input int lim);
        int n;
        n = 0;
        while (locked_o !== e && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, locked_o}, {31'h0, e});
    endtask

    // Rising edges of the three outputs over a span of system cycles.
    task automatic count_rises(input int span);
        logic [2:0] p, v;
        p  = outs;
        n0 = 0;
        n1 = 0;
        n2 = 0;
        repeat (span)
        begin
            @(posedge clk_i);
            v  = outs;
            n0 += int'(v[0] & ~p[0]);
            n1 += int'(v[1] & ~p[1]);
            n2 += int'(v[2] & ~p[2]);
            p  = v;
        end
    endtask

    // Watchdog sized well above the roughly 1700 cycles the tests need.
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        report_and_stop();
    end

    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_rd(ADR_CTRL, q); chk(q, CTRL_RST);
        wb_rd(ADR_DIV, q); chk(q, DIV_RST);
        wb_rd(ADR_OUT, q); chk(q, OUT_RST);
        wb_rd(ADR_STAT, q); chk({31'h0, q[0]}, 32'h0);
        // Unmapped place: write dropped, read returns zero.
        wb_wr(8'h10, 32'hdead_beef);
        wb_rd(8'h10, q); chk(q, 32'h0);
        // N=1, M=2, O=1; output 0 divides by 2, output 1 by 4, output 2 off.
        wb_wr(ADR_DIV, 32'h0000_0201);
        wb_wr(ADR_OUT, 32'h0000_0010);
        for (int fb = 0; fb < 3; fb++)
        begin
            wb_wr(ADR_CTRL, 32'h30 | DW'(fb));
            pfi_fabric_model_i.hold_reset(2'h2);
            // The pin needs a few cycles to pass the filter before the outputs stop.
            repeat (4) @(posedge clk_i);
            count_rises(20); chk(DW'(n0 + n1 + n2), 32'h0);
            chk({31'h0, locked_o}, 32'h0);
            pfi_fabric_model_i.release_reset();
            // Eight whole periods of 16 cycles are needed before lock can show.
            repeat (100) @(posedge clk_i);
            chk({31'h0, locked_o}, 32'h0);
            wait_lock(1'b1, 600);
            wb_rd(ADR_STAT, q); chk({30'h0, q[5:4]}, 32'h2);
            chk_rng(DW'(q[31:16]), 15, 17);
            if (fb == 0)
            begin
                count_rises(320);
                chk_rng(DW'(n0), 18, 22);
                chk_rng(DW'(n1), 8, 12);
                chk(DW'(n2), 32'h0);
            end
        end
        // Select moved while running must be ignored.
        pfi_fabric_model_i.bad_select(2'h0);
        repeat (20) @(posedge clk_i);
        wb_rd(ADR_STAT, q); chk({30'h0, q[5:4]}, 32'h2);
        // Slowing the chosen reference breaks the period match.
        pfi_fabric_model_i.half_ns[2] = 60;
        wait_lock(1'b0, 300);
        pfi_fabric_model_i.half_ns[2] = 40;
        // Reference 0 has a 48 ns period, about 9.6 system cycles.
        wb_wr(ADR_CTRL, 32'h30);
        pfi_fabric_model_i.hold_reset(2'h0);
        pfi_fabric_model_i.release_reset();
        wait_lock(1'b1, 600);
        wb_rd(ADR_STAT, q); chk({30'h0, q[5:4]}, 32'h0);
        chk_rng(DW'(q[31:16]), 9, 11);
        // Byte lane 1 only: output 2 gets divide by 8, the other lanes keep their value.
        wb_wr(ADR_OUT, 32'hffff_02ff, 4'h2);
        wb_rd(ADR_OUT, q); chk(q, 32'h0000_0210);
        wb_wr(ADR_CTRL, 32'h70);
        // About 100 multiplier ticks in 480 cycles at M=2 over a 9.6-cycle period.
        count_rises(480);
        chk_rng(DW'(n0), 46, 54);
        chk_rng(DW'(n1), 22, 28);
        chk_rng(DW'(n2), 10, 15);
        report_and_stop();
    end
endmodule
`default_nettype wire
